/* File: hw/ctr_pkg.sv */
// constants and types shared by the counter control logic
package ctr_pkg;
    // clock and derived timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int LINE_PULSE_US   = 3000;
    localparam int LINE_PULSE_CYC  = CLK_HZ / 1_000_000 * LINE_PULSE_US;
    localparam int STROBE_HZ       = 400;
    localparam int MUX_DIGITS      = 6;
    localparam int STROBE_TICK_CYC = CLK_HZ / (STROBE_HZ * MUX_DIGITS);
    localparam int SETTLE_MS       = 1000;
    localparam int SETTLE_CYC      = CLK_HZ / 1000 * SETTLE_MS;
    localparam int DEBOUNCE_MS     = 10;
    localparam int DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;

    // program image: one value word per menu item
    localparam int VAL_W      = 16;
    localparam int N_ITEMS    = 10;
    localparam int ITEM_W     = 4;
    localparam logic [ITEM_W-1:0] ITEM_FUNC   = 4'h0;
    localparam logic [ITEM_W-1:0] ITEM_LOWER_SETPOINT  = 4'h5;
    localparam logic [ITEM_W-1:0] ITEM_UPPER_SETPOINT  = 4'h6;
    localparam logic [ITEM_W-1:0] ITEM_CFG1   = 4'h7;
    localparam logic [ITEM_W-1:0] ITEM_CALIBRATION_ITEM  = 4'h9;
    localparam logic [ITEM_W-1:0] ITEM_END    = 4'hA;
    localparam logic [N_ITEMS-1:0][VAL_W-1:0] PROG_RESET = '0;

    // fields of configuration_word_one
    localparam int GATE_POLARITY_BIT   = 4;
    localparam int INT_GATE_DISABLE_BIT = 5;

    // digit editing
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // primary_lock_jumper position codes
    localparam logic [1:0] JMP_REMOVED = 2'h0;
    localparam logic [1:0] JMP_A       = 2'h1;
    localparam logic [1:0] JMP_B       = 2'h2;
    localparam logic [1:0] JMP_C       = 2'h3;

    // digit-six strobe slot
    localparam logic [2:0] STROBE_SLOT = 3'h5;

    typedef enum logic [2:0] {
        FREQUENCY_FUNCTION,
        PERIOD_FUNCTION,
        TIME_INTERVAL_FUNCTION,
        RATIO_FUNCTION,
        TOTALIZE_FUNCTION
    } func_t;

    typedef enum logic [2:0] {
        MENU_POWERUP,
        MENU_MEASURE,
        MENU_PROMPT,
        MENU_EDIT,
        MENU_STORE
    } menu_t;
endpackage

/* File: hw/btn_debounce.sv */
// synchroniser and debouncer for a group of pushbuttons
`timescale 1ns/1ps
module btn_debounce #(
    parameter int W   = 5,
    parameter int CNT = 500_000
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] press_o
);
    localparam int CW = $clog2(CNT + 1);

    typedef struct packed {
        logic [W-1:0]          s1;
        logic [W-1:0]          s2;
        logic [W-1:0]          level;
        logic [W-1:0]          press;
        logic [W-1:0][CW-1:0]  cnt;
    } deb_t;

    deb_t r;
    deb_t r_nxt;

    // a level is accepted only after it held for the whole window
    always_comb begin
        r_nxt       = r;
        r_nxt.s1    = raw_i;
        r_nxt.s2    = r.s1;
        r_nxt.press = '0;
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] != r.level[i]) begin
                if (r.cnt[i] == CW'(CNT - 1)) begin
                    r_nxt.level[i] = r.s2[i];
                    r_nxt.press[i] = r.s2[i];
                    r_nxt.cnt[i]   = '0;
                end else begin
                    r_nxt.cnt[i] = r.cnt[i] + CW'(1);
                end
            end else begin
                r_nxt.cnt[i] = '0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign level_o = r.level;
    assign press_o = r.press;
endmodule

/* File: hw/counter_gating_and_program_menu.sv */
// gating, auxiliary outputs and front-panel program menu of the counter
`timescale 1ns/1ps
// Notes on behaviour
// - gate high-true, inverted by polarity switch
// - totalize counts A pulses while gated
// - gate disable switch: external gate times measurement
// - burst: external and internal gates combined
// - line output idles high, two low pulses
// - grounded blank pin keeps display lit
// - digit-six strobe 400 Hz, one-sixth high
// - spare D flip-flop with clock and clear
// - low, high, within-limits alarm outputs
// - program from buttons or host port
// - enter opens one-pass sequential menu
// - menu ends with save or discard, or straight back to measuring when primary lock jumper removed
// - both recall buttons reload stored program
// - lock positions C, B, A restrict items
// - panel jumper removed ignores all buttons
// - power-up loads stored program, shows function
// - measurement begins about a second later, once an A pulse is seen
// - set cycles functions, enter selects
module counter_gating_and_program_menu #(
    parameter int LINE_PULSE_CYCLES  = ctr_pkg::LINE_PULSE_CYC,
    parameter int STROBE_TICK_CYCLES = ctr_pkg::STROBE_TICK_CYC,
    parameter int SETTLE_CYCLES      = ctr_pkg::SETTLE_CYC,
    parameter int DEBOUNCE_CYCLES    = ctr_pkg::DEBOUNCE_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ext_gate_i,
    input  wire logic                       a_input_i,
    input  wire logic                       internal_gate_i,
    input  wire logic                       mains_phase_i,
    input  wire logic                       mains_present_i,
    input  wire logic                       line_pin_i,
    output logic                            line_pin_o,
    output logic                            line_pin_oe_o,
    output logic                            display_blank_o,
    output logic                            digit6_o,
    input  wire logic                       ff_clk_i,
    input  wire logic                       ff_clr_n_i,
    input  wire logic                       ff_d_i,
    output logic                            spare_q_o,
    output logic                            spare_q_n_o,
    input  wire logic [ctr_pkg::VAL_W-1:0]  reading_i,
    input  wire logic                       reading_valid_i,
    output logic                            alarm_low_o,
    output logic                            alarm_high_o,
    output logic                            alarm_go_o,
    input  wire logic                       set_btn_i,
    input  wire logic                       advance_btn_i,
    input  wire logic                       enter_btn_i,
    input  wire logic                       recall_a_btn_i,
    input  wire logic                       recall_b_btn_i,
    input  wire logic [1:0]                 primary_lock_jumper_i,
    input  wire logic                       panel_lock_jumper_i,
    input  wire logic                       host_wr_i,
    input  wire logic [ctr_pkg::ITEM_W-1:0] host_item_i,
    input  wire logic [ctr_pkg::VAL_W-1:0]  host_data_i,
    input  wire logic                       host_store_i,
    output logic                            count_pulse_o,
    output logic                            meas_gate_o,
    output logic [2:0]                      function_o,
    output logic                            show_function_o,
    output logic                            meas_mode_o,
    output logic [ctr_pkg::ITEM_W-1:0]      menu_item_o,
    output logic [1:0]                      edit_digit_o,
    output logic                            editing_o,
    output logic                            store_prompt_o,
    output logic                            store_choice_o
);
    import ctr_pkg::*;

    localparam int LW = $clog2(LINE_PULSE_CYCLES + 1);
    localparam int TW = $clog2(STROBE_TICK_CYCLES + 1);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    // synchronised input slots
    localparam int SI_GATE  = 0;
    localparam int SI_PIN   = 1;
    localparam int SI_MAINS = 2;
    localparam int SI_A     = 3;
    localparam int SI_FFCLK = 4;
    localparam int SI_FFD   = 5;
    localparam int SI_FFCLR = 6;
    localparam int NS       = 7;
    // button slots
    localparam int B_SET = 0;
    localparam int B_ADV = 1;
    localparam int B_ENT = 2;
    localparam int B_RCA = 3;
    localparam int B_RCB = 4;

    typedef struct packed {
        menu_t                          menu;
        logic [ITEM_W-1:0]              item;
        logic [1:0]                     digit;
        logic                           store_sel;
        logic [N_ITEMS-1:0][VAL_W-1:0]  act;
        logic [N_ITEMS-1:0][VAL_W-1:0]  nv;
        logic [NS-1:0]                  s1;
        logic [NS-1:0]                  s2;
        logic [NS-1:0]                  s3;
        logic [SW-1:0]                  settle_cnt;
        logic                           pulse_seen;
        logic [LW-1:0]                  line_cnt;
        logic                           line_oe;
        logic [2:0]                     oe_hist;
        logic                           keep_lit;
        logic                           blank;
        logic [TW-1:0]                  tick_cnt;
        logic [2:0]                     slot;
        logic                           strobe;
        logic                           spare_q;
        logic                           spare_qn;
        logic                           gate_meas;
        logic                           count_pulse;
        logic                           alarm_lo;
        logic                           alarm_hi;
        logic                           alarm_go;
        logic                           show_func;
        logic                           meas_mode;
    } st_t;

    st_t        r;
    st_t        r_nxt;
    logic [4:0] btn_level;
    logic [4:0] btn_press;
    logic [4:0] press;
    logic       recall;
    logic       restricted;
    logic       gate_act;
    logic       a_rise;
    logic [2:0] fn;

    // true when the item may be shown under the jumper setting
    function automatic logic item_ok(input logic [ITEM_W-1:0] idx,
                                     input logic [1:0] prim);
        if (prim == JMP_REMOVED) begin
            return (idx == ITEM_LOWER_SETPOINT) || (idx == ITEM_UPPER_SETPOINT);
        end
        return !((idx == ITEM_CALIBRATION_ITEM) && (prim != JMP_C));
    endfunction

    // first shown item at or after start, ITEM_END when none is left
    function automatic logic [ITEM_W-1:0] next_from(input logic [ITEM_W-1:0] start,
                                                    input logic [1:0] prim);
        logic [ITEM_W-1:0] res;
        res = ITEM_END;
        for (int i = N_ITEMS - 1; i >= 0; i--) begin
            if ((ITEM_W'(i) >= start) && item_ok(ITEM_W'(i), prim)) begin
                res = ITEM_W'(i);
            end
        end
        return res;
    endfunction

    // debounce window keeps contact bounce out of the menu
    btn_debounce #(
        .W   (5),
        .CNT (DEBOUNCE_CYCLES)
    ) u_btn (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .raw_i   ({recall_b_btn_i, recall_a_btn_i, enter_btn_i,
                   advance_btn_i, set_btn_i}),
        .level_o (btn_level),
        .press_o (btn_press)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        r_nxt      = r;
        fn         = r.act[ITEM_FUNC][2:0];
        restricted = (primary_lock_jumper_i == JMP_REMOVED);
        press      = panel_lock_jumper_i ? btn_press : 5'h00;
        recall     = btn_level[B_RCA] && btn_level[B_RCB]
                     && (press[B_RCA] || press[B_RCB]);
        // two-stage synchroniser, third stage only for edges
        r_nxt.s1   = {ff_clr_n_i, ff_d_i, ff_clk_i, a_input_i,
                      mains_phase_i, line_pin_i, ext_gate_i};
        r_nxt.s2   = r.s1;
        r_nxt.s3   = r.s2;
        a_rise     = r.s2[SI_A] && !r.s3[SI_A];
        gate_act   = r.s2[SI_GATE] ^ r.act[ITEM_CFG1][GATE_POLARITY_BIT];

        // totalize gating uses the same edge that counts, so no error
        r_nxt.count_pulse = (fn == TOTALIZE_FUNCTION) && a_rise && gate_act;
        // ratio gate length is the source's duty and is not policed here
        case (fn)
            FREQUENCY_FUNCTION, PERIOD_FUNCTION, RATIO_FUNCTION: begin
                if (r.act[ITEM_CFG1][INT_GATE_DISABLE_BIT]) begin
                    r_nxt.gate_meas = gate_act;
                end else begin
                    r_nxt.gate_meas = internal_gate_i && gate_act;
                end
            end
            default: begin
                r_nxt.gate_meas = internal_gate_i;
            end
        endcase

        // line output: each mains edge pulls the pin low for a while
        if (mains_present_i && (r.s2[SI_MAINS] ^ r.s3[SI_MAINS])) begin
            r_nxt.line_cnt = LW'(LINE_PULSE_CYCLES - 1);
            r_nxt.line_oe  = 1'b1;
        end else if (r.line_cnt != '0) begin
            r_nxt.line_cnt = r.line_cnt - LW'(1);
        end else begin
            r_nxt.line_oe  = 1'b0;
        end
        // pin read as an input only once our own drive has settled
        r_nxt.oe_hist = {r.oe_hist[1:0], r.line_oe};
        if (!r.line_oe && (r.oe_hist == 3'h0)) begin
            r_nxt.keep_lit = !r.s2[SI_PIN];
        end
        r_nxt.blank = !mains_present_i && !r.keep_lit;

        // multiplex divider: one enable per digit slot
        if (r.tick_cnt == TW'(STROBE_TICK_CYCLES - 1)) begin
            r_nxt.tick_cnt = '0;
            r_nxt.slot     = (r.slot == STROBE_SLOT) ? 3'h0 : r.slot + 3'h1;
        end else begin
            r_nxt.tick_cnt = r.tick_cnt + TW'(1);
        end
        r_nxt.strobe = (r_nxt.slot == STROBE_SLOT);

        // spare flip-flop; sampling limits its toggle rate to clk/4
        if (!r.s2[SI_FFCLR]) begin
            r_nxt.spare_q = 1'b0;
        end else if (r.s2[SI_FFCLK] && !r.s3[SI_FFCLK]) begin
            r_nxt.spare_q = r.s2[SI_FFD];
        end
        r_nxt.spare_qn = !r_nxt.spare_q;

        // alarms follow each finished reading
        if (reading_valid_i) begin
            r_nxt.alarm_lo = reading_i < r.act[ITEM_LOWER_SETPOINT];
            r_nxt.alarm_hi = reading_i > r.act[ITEM_UPPER_SETPOINT];
            r_nxt.alarm_go = !(reading_i < r.act[ITEM_LOWER_SETPOINT])
                             && !(reading_i > r.act[ITEM_UPPER_SETPOINT]);
        end

        if (a_rise) begin
            r_nxt.pulse_seen = 1'b1;
        end

        // program menu
        case (r.menu)
            MENU_POWERUP: begin
                r_nxt.act       = r.nv;
                r_nxt.show_func = 1'b1;
                if (r.settle_cnt != SW'(SETTLE_CYCLES - 1)) begin
                    r_nxt.settle_cnt = r.settle_cnt + SW'(1);
                end else if (r.pulse_seen) begin
                    r_nxt.menu      = MENU_MEASURE;
                    r_nxt.show_func = 1'b0;
                    r_nxt.meas_mode = 1'b1;
                end
            end
            MENU_MEASURE: begin
                r_nxt.meas_mode = 1'b1;
                if (press[B_ENT] && next_from(ITEM_FUNC, primary_lock_jumper_i) != ITEM_END) begin
                    r_nxt.menu      = MENU_PROMPT;
                    r_nxt.item      = next_from(ITEM_FUNC, primary_lock_jumper_i);
                    r_nxt.meas_mode = 1'b0;
                end
            end
            MENU_PROMPT: begin
                if (press[B_ENT]) begin
                    r_nxt.item = next_from(r.item + ITEM_W'(1), primary_lock_jumper_i);
                end else if (press[B_SET] && (r.item == ITEM_FUNC)) begin
                    r_nxt.act[ITEM_FUNC] = VAL_W'((fn == TOTALIZE_FUNCTION) ?
                                           3'h0 : fn + 3'h1);
                end else if (press[B_ADV] && (r.item != ITEM_FUNC)) begin
                    r_nxt.menu  = MENU_EDIT;
                    r_nxt.digit = 2'h0;
                end
            end
            MENU_EDIT: begin
                if (press[B_ENT]) begin
                    if (restricted) begin
                        r_nxt.nv[r.item] = r.act[r.item];
                    end
                    r_nxt.menu = MENU_PROMPT;
                    r_nxt.item = next_from(r.item + ITEM_W'(1), primary_lock_jumper_i);
                end else if (press[B_SET]) begin
                    r_nxt.act[r.item][{r.digit, 2'b00} +: 4] =
                        (r.act[r.item][{r.digit, 2'b00} +: 4] >= DIGIT_MAX) ? 4'h0 :
                        r.act[r.item][{r.digit, 2'b00} +: 4] + 4'h1;
                end else if (press[B_ADV]) begin
                    r_nxt.digit = r.digit + 2'h1;
                end
            end
            MENU_STORE: begin
                if (press[B_ENT]) begin
                    if (r.store_sel && (primary_lock_jumper_i != JMP_A)) begin
                        r_nxt.nv = r.act;
                    end
                    r_nxt.menu      = MENU_MEASURE;
                    r_nxt.meas_mode = 1'b1;
                end else if (press[B_SET]) begin
                    r_nxt.store_sel = !r.store_sel;
                end
            end
            default: begin
                r_nxt.menu = MENU_MEASURE;
            end
        endcase
        // past the last shown item: save choice, or back home when restricted
        if (((r.menu == MENU_PROMPT) || (r.menu == MENU_EDIT))
            && (r_nxt.item == ITEM_END)) begin
            r_nxt.item      = ITEM_FUNC;
            r_nxt.store_sel = 1'b0;
            r_nxt.menu      = restricted ? MENU_MEASURE : MENU_STORE;
            r_nxt.meas_mode = restricted;
        end

        if (recall && (r.menu != MENU_POWERUP)) begin
            r_nxt.act = r.nv;
        end
        // host port wins over the panel in the same cycle
        if (host_wr_i && (host_item_i < ITEM_END)) begin
            r_nxt.act[host_item_i] = host_data_i;
        end
        if (host_store_i) begin
            r_nxt.nv = r.act;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r           <= '0;
            r.menu      <= MENU_POWERUP;
            r.act       <= PROG_RESET;
            r.nv        <= PROG_RESET;
            r.s1        <= '1;
            r.s2        <= '1;
            r.s3        <= '1;
            r.spare_qn  <= 1'b1;
            r.show_func <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign line_pin_o      = 1'b0;
    assign line_pin_oe_o   = r.line_oe;
    assign display_blank_o = r.blank;
    assign digit6_o        = r.strobe;
    assign spare_q_o       = r.spare_q;
    assign spare_q_n_o     = r.spare_qn;
    assign alarm_low_o     = r.alarm_lo;
    assign alarm_high_o    = r.alarm_hi;
    assign alarm_go_o      = r.alarm_go;
    assign count_pulse_o   = r.count_pulse;
    assign meas_gate_o     = r.gate_meas;
    assign function_o      = r.act[ITEM_FUNC][2:0];
    assign show_function_o = r.show_func;
    assign meas_mode_o     = r.meas_mode;
    assign menu_item_o     = r.item;
    assign edit_digit_o    = r.digit;
    assign editing_o       = (r.menu == MENU_EDIT);
    assign store_prompt_o  = (r.menu == MENU_STORE);
    assign store_choice_o  = r.store_sel;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_total_gated: assert property (count_pulse_o |->
        $past(gate_act) && $past(a_rise)) else $error("count pulse without gate");
    a_line_pulse: assert property ($rose(line_pin_oe_o) |->
        line_pin_oe_o[*2]) else $error("line pulse too short");
    a_strobe_slot: assert property ($rose(digit6_o) |->
        $past(r.slot) == 3'h4 && r.slot == STROBE_SLOT) else $error("strobe slot wrong");
    a_panel_lock: assert property ((!panel_lock_jumper_i && r.menu == MENU_MEASURE)
        |=> r.menu == MENU_MEASURE) else $error("menu opened while locked");
    a_store_locked: assert property ((r.menu == MENU_STORE
        && primary_lock_jumper_i == JMP_A && !host_store_i) |=> $stable(r.nv))
        else $error("store while locked");
    a_calibration_item_hidden: assert property ((r.menu == MENU_PROMPT
        && $stable(primary_lock_jumper_i) && primary_lock_jumper_i != JMP_C)
        |-> r.item != ITEM_CALIBRATION_ITEM) else $error("calibration shown while locked");
    a_recall_copy: assert property ((recall && r.menu != MENU_POWERUP && !host_wr_i)
        |=> r.act == $past(r.nv)) else $error("recall did not reload");
    a_settle_wait: assert property ($fell(show_function_o) |->
        $past(r.pulse_seen) && $past(r.settle_cnt) == SW'(SETTLE_CYCLES - 1))
        else $error("left power-up early");
    // go judged from the reading and setpoints themselves, not from the other alarms
    a_alarm_go: assert property (reading_valid_i |=>
        alarm_go_o == ($past(reading_i) >= $past(r.act[ITEM_LOWER_SETPOINT])
                       && $past(reading_i) <= $past(r.act[ITEM_UPPER_SETPOINT])))
        else $error("go alarm wrong");
endmodule

/* File: test/panel_operator.sv */
// pushbutton operator model for the front panel
`timescale 1ns/1ps
module panel_operator (
    input  wire logic       clk_i,
    input  wire logic [4:0] req_i,
    output logic      [4:0] btn_o
);
    logic [4:0] cnt_r = 5'h0;
    initial btn_o = 5'h0;
    // hold 11 cycles, release 10: debounce must see a clean press and release
    always @(posedge clk_i) begin
        if (cnt_r == 5'h0 && req_i != 5'h0) begin
            btn_o <= req_i;
            cnt_r <= 5'h14;
        end else if (cnt_r != 5'h0) begin
            cnt_r <= cnt_r - 5'h1;
            if (cnt_r == 5'hA) btn_o <= 5'h0;
        end
    end
endmodule

/* File: test/counter_gating_and_program_menu_tb.sv */
// self-checking bench of the gating, auxiliary outputs and menu
`timescale 1ns/1ps
module counter_gating_and_program_menu_tb;
    import ctr_pkg::*;
    logic clk_i = 0, rst_n_i = 0, ext_gate_i = 0, a_input_i = 0, internal_gate_i = 0;
    logic mains_phase_i = 0, mains_present_i = 0, ff_clk_i = 0, ff_clr_n_i = 1, ff_d_i = 0;
    logic reading_valid_i = 0, panel_lock_jumper_i = 1, host_wr_i = 0, host_store_i = 0, gnd = 0;
    logic [15:0] reading_i = 0, host_data_i = 0, v;
    logic [3:0]  host_item_i = 0, menu_item_o;
    logic [1:0]  primary_lock_jumper_i = JMP_C, edit_digit_o;
    logic line_pin_o, line_pin_oe_o, display_blank_o, digit6_o, spare_q_o, spare_q_n_o, alarm_low_o;
    logic alarm_high_o, alarm_go_o, count_pulse_o, meas_gate_o, show_function_o, meas_mode_o;
    logic editing_o, store_prompt_o, store_choice_o, g;
    logic [2:0]  function_o, expq[$];
    logic [4:0]  req = 0, btn;
    logic [31:0] seed = 7991;
    int failures = 0, comparisons = 0, oe_n = 0, d6_n = 0, pulses = 0;
    wire set_btn_i = btn[0], advance_btn_i = btn[1], enter_btn_i = btn[2];
    wire recall_a_btn_i = btn[3], recall_b_btn_i = btn[4];
    // open-drain pin: pulled up unless grounded by the user or pulled by the block
    wire line_pin_i = line_pin_oe_o ? line_pin_o : ~gnd;
    counter_gating_and_program_menu #(.LINE_PULSE_CYCLES(20), .STROBE_TICK_CYCLES(4),
        .SETTLE_CYCLES(30), .DEBOUNCE_CYCLES(3)) uut (.*);
    panel_operator op (.clk_i(clk_i), .req_i(req), .btn_o(btn));
    always #10 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic press(input logic [4:0] b);
        req = b;
        cyc(1);
        req = 0;
        cyc(26);
    endtask
    task automatic host(input logic [3:0] it, input logic [15:0] d);
        host_item_i = it;
        host_data_i = d;
        host_wr_i = 1;
        cyc(1);
        host_wr_i = 0;
        cyc(1);
    endtask
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task give_verdict;
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // pulse counters; a window is opened by clearing one
    always @(posedge clk_i) begin
        oe_n += line_pin_oe_o;
        d6_n += digit6_o;
        pulses += count_pulse_o;
    end
    // alarm monitor: oldest note against outputs one edge after valid
    always @(posedge clk_i) if (reading_valid_i === 1'b1) begin
        #2;
        chk("alarm", expq.pop_front(), {alarm_low_o, alarm_high_o, alarm_go_o});
    end
    initial begin
        #200000;
        failures++;
        give_verdict;
    end
    initial begin
        cyc(5);
        chk("qn_rst", 1, spare_q_n_o);
        chk("showf_rst", 1, show_function_o);
        cyc(1);
        rst_n_i = 1;
        cyc(40);
        chk("wait_pulses", 0, meas_mode_o);
        a_input_i = 1;
        cyc(3);
        a_input_i = 0;
        cyc(6);
        chk("meas", 1, meas_mode_o);
        panel_lock_jumper_i = 0;
        press(5'h04);
        chk("locked", 1, meas_mode_o);
        panel_lock_jumper_i = 1;
        // ratio function; each gate lasts a few cycles, its length is not policed
        host(ITEM_FUNC, 16'h0003);
        // pol, disable, ext, internal in all sixteen combinations
        for (int i = 0; i < 16; i++) begin
            host(ITEM_CFG1, {10'h0, i[2], i[3], 4'h0});
            ext_gate_i = i[1];
            internal_gate_i = i[0];
            cyc(5);
            g = i[1] ^ i[3];
            chk("gate", i[2] ? g : (i[0] & g), meas_gate_o);
        end
        host(ITEM_CFG1, 16'h0000);
        host(ITEM_FUNC, 16'h0004);
        pulses = 0;
        for (int i = 0; i < 6; i++) begin
            ext_gate_i = i < 3;
            a_input_i = 1;
            cyc(4);
            a_input_i = 0;
            cyc(4);
        end
        cyc(6);
        chk("count", 3, pulses);
        // A raised before the gate opens, so only line pulses count below
        a_input_i = 1;
        cyc(4);
        ext_gate_i = 1;
        for (int p = 0; p < 2; p++) begin
            mains_present_i = p;
            mains_phase_i = ~mains_phase_i;
            oe_n = 0;
            pulses = 0;
            // pin routed to the A input: one count per line pulse
            repeat (40) begin
                a_input_i = line_pin_i;
                cyc(1);
            end
            chk("line", p ? 20 : 0, oe_n);
            chk("line_a", p, pulses);
            gnd = p;
            mains_present_i = 0;
            cyc(10);
            chk("blank", p ? 0 : 1, display_blank_o);
        end
        d6_n = 0;
        cyc(48);
        chk("digit6", 8, d6_n);
        ff_d_i = 1;
        ff_clk_i = 1;
        cyc(6);
        chk("spare", 2'h2, {spare_q_o, spare_q_n_o});
        ff_clr_n_i = 0;
        cyc(6);
        chk("clear", 2'h1, {spare_q_o, spare_q_n_o});
        host(ITEM_LOWER_SETPOINT, 16'h1000);
        host(ITEM_UPPER_SETPOINT, 16'h8000);
        // both thresholds exactly, then random readings
        for (int i = 0; i < 12; i++) begin
            v = (i < 2) ? (i ? 16'h8000 : 16'h1000) : rnd();
            reading_i = v;
            reading_valid_i = 1;
            expq.push_back({v < 16'h1000, v > 16'h8000, v >= 16'h1000 && v <= 16'h8000});
            cyc(1);
            reading_valid_i = 0;
            cyc(1);
        end
        host(ITEM_FUNC, 16'h0000);
        press(5'h04);
        chk("menu", {1'h0, ITEM_FUNC}, {meas_mode_o, menu_item_o});
        for (int i = 1; i < 6; i++) begin
            press(5'h01);
            chk("func", i % 5, function_o);
        end
        // enter to item one, advance twice: editing the second digit
        press(5'h04);
        press(5'h02);
        press(5'h02);
        chk("edit", 3'h5, {editing_o, edit_digit_o});
        // one enter leaves the edit, eight more walk past the last item
        repeat (9) press(5'h04);
        chk("store", 2'h2, {store_prompt_o, store_choice_o});
        press(5'h01);
        host(ITEM_FUNC, 16'h0002);
        press(5'h04);
        chk("saved", 1, meas_mode_o);
        // a later change is undone by recalling the saved program
        host(ITEM_FUNC, 16'h0003);
        press(5'h18);
        chk("recall", 2, function_o);
        give_verdict;
    end
endmodule
